// file: logic/pbs_bank_mon.sv
// Purpose: combines the bank supply flags into one powered level
// Assumes: flags are synchronous to mclk
// Notes: registered to give a clean level
`timescale 1ns/1ps
module pbs_bank_mon
   import pbs_pkg::*;
#(
   parameter int BANKS = NUM_BANKS
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Flags
   input wire logic [BANKS-1:0] io_bank_supply_ok,
   output logic all_banks_ok
);
   typedef struct packed {
      logic ok;
   } pbs_bank_st_t;

   pbs_bank_st_t st_reg;
   pbs_bank_st_t st_next;

   always_comb begin
      st_next.ok = &io_bank_supply_ok;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign all_banks_ok = st_reg.ok;
endmodule

// file: logic/pbs_pkg.sv
// Purpose: shared constants for the power-up brown-out sequencer
// Assumes: 20 MHz mclk
// Notes: times are in ns, counts derived from the clock period
package pbs_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_CONFIG_NS = 450000;
   localparam int T_BANK_SETTLE_NS = 2000;
   localparam int CONFIG_CYCLES = T_CONFIG_NS / CLK_PERIOD_NS;
   localparam int SETTLE_CYCLES =
      (T_BANK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   localparam int NUM_BANKS = 4;

   typedef enum logic [2:0] {
      PBS_OFF,
      PBS_DOWNLOAD,
      PBS_BANK_WAIT,
      PBS_SETTLE,
      PBS_CLEAR,
      PBS_USER
   } pbs_state_t;
endpackage

// file: logic/pbs_sequencer.sv
// Purpose: power-on reset and brown-out sequencer
// Assumes: supply comparators deliver synchronous digital flags
// Notes: low_voltage_variant picks the lower start flag
`timescale 1ns/1ps

// Summary of operation
// - Download starts when the core supply start flag asserts.
// - Download and user entry take the configuration interval.
// - User mode waits until every bank supply flag is high.
// - A late last bank gives user mode 2 us after all are powered.
// - In user mode only the core brown-out flag is watched.
// - Core brown-out clears configuration and tri-states all pins.
// - After brown-out the download restarts on the restart flag.
// - Registers are cleared and released before tri-states lift.
// - With the clear pin option, a low clear pin holds clears.
// - With the enable pin option, outputs wait for that pin.
// - Pins stay tri-stated with pull-ups until user mode.
module pbs_sequencer
   import pbs_pkg::*;
#(
   parameter int BANKS = NUM_BANKS,
   parameter int CONFIG_CNT = CONFIG_CYCLES,
   parameter int SETTLE_CNT = SETTLE_CYCLES
)
(
   // Clock and reset
   mclk,
   rstn,
   // Supply flags
   core_supply_start,
   core_supply_start_lv,
   core_supply_restart,
   core_supply_brownout,
   io_bank_supply_ok,
   // Options and board pins
   low_voltage_variant,
   clear_pin_option,
   global_clear_pin_n,
   oe_pin_option,
   global_output_enable_pin,
   // Sequencer outputs
   config_sram_reset,
   download_active,
   user_mode,
   reg_clear,
   io_tristate,
   io_pullup_en
);
   input wire logic mclk;
   input wire logic rstn;
   input wire logic core_supply_start;
   input wire logic core_supply_start_lv;
   input wire logic core_supply_restart;
   input wire logic core_supply_brownout;
   input wire logic [BANKS-1:0] io_bank_supply_ok;
   input wire logic low_voltage_variant;
   input wire logic clear_pin_option;
   input wire logic global_clear_pin_n;
   input wire logic oe_pin_option;
   input wire logic global_output_enable_pin;
   output logic config_sram_reset;
   output logic download_active;
   output logic user_mode;
   output logic reg_clear;
   output logic io_tristate;
   output logic io_pullup_en;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      pbs_state_t state;
      logic brownout_seen;
      logic sram_reset;
      logic dl;
      logic umode;
      logic clr;
      logic tri_st;
      logic pull;
   } pbs_seq_st_t;

   pbs_seq_st_t st_reg;
   pbs_seq_st_t st_next;
   logic banks_ok;
   logic start_flag;
   logic tmr_start;
   logic [CNT_W-1:0] tmr_limit;

   pbs_tmr_if tif ();

   pbs_timer u_timer (
      .mclk(mclk),
      .rstn(rstn),
      .t(tif.tmr)
   );

   pbs_bank_mon #(.BANKS(BANKS)) u_banks (
      .mclk(mclk),
      .rstn(rstn),
      .io_bank_supply_ok(io_bank_supply_ok),
      .all_banks_ok(banks_ok)
   );

   assign tif.start = tmr_start;
   assign tif.limit = tmr_limit;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      start_flag = low_voltage_variant ? core_supply_start_lv
                                       : core_supply_start;
      st_next = st_reg;
      tmr_start = 1'b0;
      tmr_limit = CNT_W'(CONFIG_CNT);
      case (st_reg.state)
         PBS_OFF: begin
            // Restart after brown-out needs the higher restart flag
            if (st_reg.brownout_seen ? core_supply_restart
                                     : start_flag) begin
               st_next.state = PBS_DOWNLOAD;
               tmr_start = 1'b1;
            end
         end
         PBS_DOWNLOAD: begin
            if (tif.done) begin
               st_next.state = banks_ok ? PBS_CLEAR
                                        : PBS_BANK_WAIT;
            end
         end
         PBS_BANK_WAIT: begin
            if (banks_ok) begin
               st_next.state = PBS_SETTLE;
               tmr_start = 1'b1;
            end
         end
         PBS_SETTLE: begin
            tmr_limit = CNT_W'(SETTLE_CNT);
            if (!banks_ok) begin
               st_next.state = PBS_BANK_WAIT;
            end else if (tif.done) begin
               st_next.state = PBS_CLEAR;
            end
         end
         PBS_CLEAR: begin
            st_next.state = PBS_USER;
         end
         PBS_USER: begin
         end
         default: begin
            st_next.state = PBS_OFF;
         end
      endcase
      // Brown-out watch ignores bank flags
      if (st_reg.state != PBS_OFF && core_supply_brownout) begin
         st_next.state = PBS_OFF;
         st_next.brownout_seen = 1'b1;
         tmr_start = 1'b1;
      end
      st_next.sram_reset = (st_next.state == PBS_OFF);
      st_next.dl = (st_next.state == PBS_DOWNLOAD);
      st_next.umode = (st_next.state == PBS_USER);
      // Clears release before tri-states, optional pin hold
      st_next.clr = !(st_next.state inside {PBS_CLEAR, PBS_USER}) ||
                    (st_next.state == PBS_CLEAR) ||
                    (clear_pin_option && !global_clear_pin_n);
      st_next.tri_st = !(st_next.state == PBS_USER && st_reg.umode) ||
                       (oe_pin_option &&
                        !global_output_enable_pin);
      st_next.pull = (st_next.state != PBS_USER);
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '{state: PBS_OFF, brownout_seen: 1'b0,
                     sram_reset: 1'b1, dl: 1'b0, umode: 1'b0,
                     clr: 1'b1, tri_st: 1'b1, pull: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   assign config_sram_reset = st_reg.sram_reset;
   assign download_active = st_reg.dl;
   assign user_mode = st_reg.umode;
   assign reg_clear = st_reg.clr;
   assign io_tristate = st_reg.tri_st;
   assign io_pullup_en = st_reg.pull;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_START: assert property (@(posedge mclk) disable iff (!rstn)
      (st_reg.state == PBS_OFF && !st_reg.brownout_seen &&
       !low_voltage_variant && core_supply_start &&
       !core_supply_brownout) |=> download_active)
      else $error("download did not start");
   AST_NO_EARLY_USER: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(user_mode) |-> $past(banks_ok, 2))
      else $error("user mode without banks");
   AST_DL_TIME: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(download_active) |-> download_active [*8])
      else $error("download ended early");
   AST_BROWNOUT: assert property (@(posedge mclk) disable iff (!rstn)
      (user_mode && core_supply_brownout) |=>
      (config_sram_reset && io_tristate && !user_mode))
      else $error("brown-out not handled");
   AST_BANK_IGNORE: assert property (@(posedge mclk) disable iff (!rstn)
      (user_mode && !core_supply_brownout) |=> user_mode)
      else $error("user mode left without brown-out");
   AST_HYST: assert property (@(posedge mclk) disable iff (!rstn)
      (st_reg.state == PBS_OFF && st_reg.brownout_seen &&
       !core_supply_restart) |=> !download_active)
      else $error("restart below restart level");
   AST_ORDER: assert property (@(posedge mclk) disable iff (!rstn)
      $fell(io_tristate) |-> $past(!reg_clear || clear_pin_option))
      else $error("tri-state released before clear");
   AST_CLR_PIN: assert property (@(posedge mclk) disable iff (!rstn)
      (clear_pin_option && !global_clear_pin_n) |=> reg_clear)
      else $error("clear pin not honoured");
   AST_OE_PIN: assert property (@(posedge mclk) disable iff (!rstn)
      (oe_pin_option && !global_output_enable_pin) |=> io_tristate)
      else $error("output enable pin not honoured");
   AST_PULL: assert property (@(posedge mclk) disable iff (!rstn)
      !user_mode |-> (io_pullup_en && io_tristate))
      else $error("pins released before user mode");
   AST_SETTLE: assert property (@(posedge mclk) disable iff (!rstn)
      (st_reg.state == PBS_BANK_WAIT && banks_ok && !core_supply_brownout)
      |=> (st_reg.state == PBS_SETTLE) && tif.done == 1'b0)
      else $error("settle did not restart");

   AST_LV_START: assert property (
      @(posedge mclk) disable iff (!rstn)
      (st_reg.state == PBS_OFF && !st_reg.brownout_seen &&
       low_voltage_variant && core_supply_start_lv &&
       !core_supply_brownout) |=> download_active)
      else $error("low voltage download did not start");

   AST_DL_SRAM: assert property (
      @(posedge mclk) disable iff (!rstn)
      download_active |-> !config_sram_reset)
      else $error("sram held in reset during download");

   AST_OFF_SRAM: assert property (
      @(posedge mclk) disable iff (!rstn)
      config_sram_reset |-> (!download_active && !user_mode))
      else $error("sram reset while active");

   AST_DL_STOP: assert property (
      @(posedge mclk) disable iff (!rstn)
      (download_active && tif.done) |=> !download_active)
      else $error("download overran its interval");

   AST_USER_CLEARED: assert property (
      @(posedge mclk) disable iff (!rstn)
      $rose(user_mode) |-> $past(reg_clear))
      else $error("user mode without prior clear");

   AST_USER_TRI: assert property (
      @(posedge mclk) disable iff (!rstn)
      $rose(user_mode) |-> io_tristate)
      else $error("tri-state lifted with register release");

   AST_BO_DL: assert property (
      @(posedge mclk) disable iff (!rstn)
      (download_active && core_supply_brownout) |=>
      (config_sram_reset && !download_active))
      else $error("brown-out during download not handled");

   AST_BO_SEEN: assert property (
      @(posedge mclk) disable iff (!rstn)
      (st_reg.state != PBS_OFF && core_supply_brownout) |=>
      st_reg.brownout_seen)
      else $error("brown-out not remembered");

   AST_RESTART: assert property (
      @(posedge mclk) disable iff (!rstn)
      (st_reg.state == PBS_OFF && st_reg.brownout_seen &&
       core_supply_restart && !core_supply_brownout) |=> download_active)
      else $error("download did not restart");

   AST_WAIT_HOLD: assert property (
      @(posedge mclk) disable iff (!rstn)
      (st_reg.state == PBS_BANK_WAIT && !banks_ok &&
       !core_supply_brownout) |=> (st_reg.state == PBS_BANK_WAIT))
      else $error("bank wait left without banks");

   AST_SETTLE_DROP: assert property (
      @(posedge mclk) disable iff (!rstn)
      (st_reg.state == PBS_SETTLE && !banks_ok &&
       !core_supply_brownout) |=> (st_reg.state == PBS_BANK_WAIT))
      else $error("settle kept after bank loss");

   AST_TMR_RESTART: assert property (
      @(posedge mclk) disable iff (!rstn)
      $rose(download_active) |-> !tif.done)
      else $error("interval timer not restarted");

   AST_CLEAR_ONE: assert property (
      @(posedge mclk) disable iff (!rstn)
      (st_reg.state == PBS_CLEAR && !core_supply_brownout) |=> user_mode)
      else $error("clear phase not followed by user mode");

   AST_UMODE_PULL: assert property (
      @(posedge mclk) disable iff (!rstn)
      user_mode |-> !io_pullup_en)
      else $error("pull-ups left on in user mode");

   AST_CLR_FREE: assert property (
      @(posedge mclk) disable iff (!rstn)
      (user_mode && !clear_pin_option && !core_supply_brownout) |=>
      !reg_clear)
      else $error("registers held cleared without clear pin");
endmodule

// file: logic/pbs_timer.sv
// Purpose: interval counter for download and bank settle timing
// Assumes: limit is stable while counting
// Notes: done is a level held until the next start
`timescale 1ns/1ps
module pbs_timer
   import pbs_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Control
   pbs_tmr_if.tmr t
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic done;
   } pbs_tmr_st_t;

   pbs_tmr_st_t st_reg;
   pbs_tmr_st_t st_next;

   always_comb begin
      st_next = st_reg;
      if (t.start) begin
         st_next.cnt = '0;
         st_next.done = 1'b0;
      end else if (!st_reg.done) begin
         if (st_reg.cnt >= t.limit - CNT_W'(1)) begin
            st_next.done = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign t.done = st_reg.done;
endmodule

// file: logic/pbs_tmr_if.sv
// Purpose: connects the sequencer to its interval timer
// Assumes: one clock domain
// Notes: start restarts the count from zero
`timescale 1ns/1ps
interface pbs_tmr_if;
   import pbs_pkg::*;
   logic start;
   logic [CNT_W-1:0] limit;
   logic done;
   modport ctl (output start, output limit, input done);
   modport tmr (input start, input limit, output done);
endinterface

// file: tb/pbs_sequencer_tb_top.sv
// Purpose: self-checking bench for the power-up brown-out sequencer
// Assumes: shortened interval counts
// Notes: every scenario resets the sequencer first
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, a, e); end end
module pbs_sequencer_tb_top;
   import pbs_pkg::*;
   localparam int CFG = 20;
   localparam int STL = 4;
   logic mclk, rstn, lv_sel, clr_opt, oe_opt;
   logic c_start, c_start_lv, c_restart, c_bo, clr_n, oe_pin;
   logic [NUM_BANKS-1:0] banks;
   logic sram_rst, dl_act, user, rclr, tri_st, pull;
   int fail_count, cmp_count, n;

   pbs_supply_model sup_u (.core_supply_start(c_start),
      .core_supply_start_lv(c_start_lv), .core_supply_restart(c_restart),
      .core_supply_brownout(c_bo), .io_bank_supply_ok(banks),
      .global_clear_pin_n(clr_n), .global_output_enable_pin(oe_pin));

   pbs_sequencer #(.CONFIG_CNT(CFG), .SETTLE_CNT(STL)) dut_u (.mclk(mclk),
      .rstn(rstn), .core_supply_start(c_start),
      .core_supply_start_lv(c_start_lv), .core_supply_restart(c_restart),
      .core_supply_brownout(c_bo), .io_bank_supply_ok(banks),
      .low_voltage_variant(lv_sel), .clear_pin_option(clr_opt),
      .global_clear_pin_n(clr_n), .oe_pin_option(oe_opt),
      .global_output_enable_pin(oe_pin), .config_sram_reset(sram_rst),
      .download_active(dl_act), .user_mode(user), .reg_clear(rclr),
      .io_tristate(tri_st), .io_pullup_en(pull));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic step(input int k);
      repeat (k) @(posedge mclk);
      #5;
   endtask

   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wait_user(input int lim, output int cnt);
      cnt = 0;
      while (user !== 1'b1 && cnt < lim) begin
         step(1);
         cnt++;
      end
      `CHK(user, 1'b1)
      if (user !== 1'b1) final_report();
   endtask

   task automatic do_reset();
      rstn = 1'b0;
      lv_sel = 1'b0;
      clr_opt = 1'b0;
      oe_opt = 1'b0;
      sup_u.core_level(1500);
      sup_u.set_banks('0);
      sup_u.set_pins(1'b1, 1'b1);
      step(3);
      `CHK({sram_rst, rclr, tri_st, pull}, 4'hF)
      `CHK({user, dl_act}, 2'h0)
      rstn = 1'b1;
      step(1);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_powerup();
      do_reset();
      sup_u.set_banks('1);
      sup_u.core_level(1800);
      step(1);
      `CHK(dl_act, 1'b1)
      `CHK({tri_st, pull}, 2'h3)
      wait_user(CFG + 6, n);
      `CHK(n >= CFG - 1, 1'b1)
      `CHK({rclr, pull, tri_st}, 3'h1)
      step(1);
      `CHK(tri_st, 1'b0)
      sup_u.set_banks('0);
      step(4);
      `CHK(user, 1'b1)
      sup_u.core_level(1400);
      step(1);
      `CHK({sram_rst, tri_st, pull, user}, 4'hE)
      sup_u.core_level(1600);
      step(CFG);
      `CHK(dl_act, 1'b0)
      sup_u.set_banks('1);
      sup_u.core_level(1700);
      step(1);
      `CHK(dl_act, 1'b1)
      step(CFG / 2);
      sup_u.core_level(1300);
      step(1);
      `CHK({dl_act, sram_rst}, 2'h1)
      sup_u.core_level(1700);
      step(1);
      wait_user(CFG + 6, n);
      `CHK(n >= CFG - 1, 1'b1)
      $display("test powerup and brownout done");
   endtask

   task automatic t_late_banks();
      do_reset();
      sup_u.core_level(1800);
      step(CFG + 8);
      `CHK({user, tri_st}, 2'h1)
      sup_u.set_banks(NUM_BANKS'(7));
      step(STL + 4);
      `CHK(user, 1'b0)
      sup_u.set_banks('1);
      step(1);
      wait_user(STL + 6, n);
      `CHK(n >= STL - 1, 1'b1)
      $display("test late banks done");
   endtask

   task automatic t_low_voltage();
      do_reset();
      sup_u.set_banks('1);
      sup_u.core_level(1600);
      step(2);
      `CHK(dl_act, 1'b0)
      lv_sel = 1'b1;
      step(2);
      `CHK(dl_act, 1'b1)
      wait_user(CFG + 6, n);
      `CHK(n >= CFG - 2, 1'b1)
      $display("test low voltage done");
   endtask

   task automatic t_pins();
      do_reset();
      clr_opt = 1'b1;
      oe_opt = 1'b1;
      sup_u.set_pins(1'b0, 1'b0);
      sup_u.set_banks('1);
      sup_u.core_level(1800);
      wait_user(CFG + 8, n);
      step(3);
      `CHK(rclr, 1'b1)
      `CHK(tri_st, 1'b1)
      sup_u.set_pins(1'b0, 1'b1);
      step(1);
      `CHK({tri_st, rclr}, 2'h1)
      sup_u.set_pins(1'b1, 1'b1);
      step(1);
      `CHK(rclr, 1'b0)
      $display("test board pins done");
   endtask

   initial begin
      fail_count = 0;
      cmp_count = 0;
      t_powerup();
      t_late_banks();
      t_low_voltage();
      t_pins();
      final_report();
   end
endmodule

// file: tb/pbs_supply_model.sv
// Purpose: board-side model of the supply monitors and control pins
// Assumes: its tasks are called just after an mclk edge
// Notes: the core level is given in millivolts and mapped to flags
`timescale 1ns/1ps
module pbs_supply_model
   import pbs_pkg::*;
(
   // Core supply flags
   output logic core_supply_start,
   output logic core_supply_start_lv,
   output logic core_supply_restart,
   output logic core_supply_brownout,
   // Bank flags and board pins
   output logic [NUM_BANKS-1:0] io_bank_supply_ok,
   output logic global_clear_pin_n,
   output logic global_output_enable_pin
);
   // Flags from one level, so brown-out and restart never overlap
   task automatic core_level(input int mv);
      core_supply_start = (mv >= 1700);
      core_supply_start_lv = (mv >= 1550);
      core_supply_restart = (mv >= 1700);
      core_supply_brownout = (mv <= 1400);
   endtask

   task automatic set_banks(input logic [NUM_BANKS-1:0] v);
      io_bank_supply_ok = v;
   endtask

   task automatic set_pins(input logic clr_n, input logic oe);
      global_clear_pin_n = clr_n;
      global_output_enable_pin = oe;
   endtask

   initial begin
      core_level(1500);
      set_banks('0);
      set_pins(1'b1, 1'b1);
   end
endmodule
